// ---- core/mrem_regs.svh ----
`ifndef MREM_REGS_SVH
`define MREM_REGS_SVH
// Errors in one hour that shut reporting off
`define MREM_ERR_LIMIT        8'h0A
// Clocks between two scrub reads
`define MREM_SCRUB_INTERVAL   32'h0000_8000
// Error type index of correctable memory errors
`define MREM_TYPE_CE          0
`define MREM_TYPE_SCRUB       1
`endif

// ---- core/mrem_pkg.sv ----
package mrem_pkg;
  typedef enum logic [4:0] {
    MREM_IDLE   = 5'h01,
    MREM_HOST   = 5'h02,
    MREM_MIRROR = 5'h04,
    MREM_SCRUB  = 5'h08,
    MREM_WBACK  = 5'h10
  } mrem_state_type;
  typedef enum logic [1:0] {
    MREM_MODE_PLAIN  = 2'h0,
    MREM_MODE_SPARE  = 2'h1,
    MREM_MODE_MIRROR = 2'h2
  } mrem_mode_type;
endpackage

// ---- core/mrem_throttle.sv ----
`timescale 1ns/1ns
`include "mrem_regs.svh"
// Per-type error counter with hourly window and one final shut-off event
module mrem_throttle #(
  parameter int CW = 8
) (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic ce,
  input  wire logic hour_tick,
  input  wire logic err_evt,
  output logic      report_evt,
  output logic      off_evt,
  output logic      disabled
);
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic          dis_r;
  logic          dis_nxt;
  logic          rep_r;
  logic          rep_nxt;
  logic          off_r;
  logic          off_nxt;

  // The limit of ten needs at least four counter bits
  if (CW < 4) begin : g_bad_cw
    $error("counter too narrow");
  end

  // Counting, window restart and shut-off
  always_comb begin
    cnt_nxt = cnt_r;
    dis_nxt = dis_r;
    rep_nxt = 1'b0;
    off_nxt = 1'b0;
    if (hour_tick && !dis_r) begin
      cnt_nxt = '0;
    end
    if (err_evt && !dis_r) begin
      cnt_nxt = (hour_tick ? CW'(0) : cnt_r) + CW'(1);
      if (cnt_nxt == CW'(`MREM_ERR_LIMIT)) begin
        dis_nxt = 1'b1;
        off_nxt = 1'b1;
      end else begin
        rep_nxt = 1'b1;
      end
    end
  end

  // Registers; the disable flag is cleared only by reboot reset, the count also by the hour tick
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= '0;
      dis_r <= 1'b0;
      rep_r <= 1'b0;
      off_r <= 1'b0;
    end else if (ce) begin
      cnt_r <= cnt_nxt;
      dis_r <= dis_nxt;
      rep_r <= rep_nxt;
      off_r <= off_nxt;
    end
  end

  assign report_evt = rep_r;
  assign off_evt    = off_r;
  assign disabled   = dis_r;

  AST_OFF_ONCE: assert property (@(posedge clk) disable iff (!nrst)
    (off_r && ce) |=> !off_r && dis_r) else $error("shut-off event repeated");
  AST_QUIET: assert property (@(posedge clk) disable iff (!nrst)
    $past(dis_r) |-> !rep_r) else $error("report after disable");
endmodule

// ---- core/mrem_core.sv ----
`timescale 1ns/1ns
`include "mrem_regs.svh"
// Contract
// - Every correctable error is corrected, and reported while reporting is on unless it comes from a mirror-copy read.
// - Ten correctable errors of one type in an hour turn reporting of that type off.
// - Once off, correction goes on but reports for that type stop for every DIMM.
// - Turning reporting off emits one final event saying so.
// - Only reset (reboot) re-enables reporting and clears the per-DIMM sparing counts.
// - The scrubber reads one DRAM location each time the scrub interval elapses.
// - A scrub read with a correctable error writes corrected data back in place.
// - A host read held by a scrub write-back is kept and served afterwards in order.
// - A primary DIMM whose error count passes the threshold is replaced by the spare.
// - Sparing and mirroring are never active together.
// - In mirroring every host write goes to primary and mirror locations.
// - In mirroring an uncorrectable read is answered from the mirror copy.
// - In mirroring only half of the memory is addressable.
module mrem_core #(
  parameter int AW       = 16,
  parameter int DW       = 64,
  parameter int NDIMM    = 4,
  parameter int DCW      = 8,
  parameter int INTERVAL = `MREM_SCRUB_INTERVAL
) (
  input  wire logic                     clk,
  input  wire logic                     nrst,
  input  wire logic                     ce,
  input  wire logic                     hour_tick,
  input  wire logic                     spare_en,
  input  wire logic                     mirror_en,
  input  wire logic [DCW-1:0]           spare_threshold,
  input  wire logic                     host_req,
  input  wire logic                     host_we,
  input  wire logic [AW-1:0]            host_addr,
  input  wire logic [DW-1:0]            host_wdata,
  output logic                          host_ready,
  output logic                          host_rvalid,
  output logic [DW-1:0]                 host_rdata,
  output logic                          host_addr_err,
  output logic                          mem_req,
  output logic                          mem_we,
  output logic [AW-1:0]                 mem_addr,
  output logic [DW-1:0]                 mem_wdata,
  output logic                          mem_use_spare,
  input  wire logic                     mem_ack,
  input  wire logic [DW-1:0]            mem_rdata,
  input  wire logic                     mem_ce_err,
  input  wire logic                     mem_ue_err,
  input  wire logic [DW-1:0]            mem_corr_data,
  output logic                          log_event,
  output logic                          log_off_event,
  output logic                          system_management_interrupt,
  output logic                          fatal_err,
  output logic [1:0]                    active_mode,
  output logic                          spare_active
);
  localparam int DIW = (NDIMM > 1) ? $clog2(NDIMM) : 1;

  // Refuse sizes the sequencer cannot serve
  if (AW < 4 || DW < 1 || NDIMM < 1 || DCW < 1 || INTERVAL < 2 || DIW >= AW) begin : g_bad_par
    $error("bad parameters");
  end

  mrem_pkg::mrem_state_type st_r, st_nxt;
  logic [31:0]   tmr_r, tmr_nxt;
  logic [AW-1:0] sc_addr_r, sc_addr_nxt;
  logic          sc_due_r, sc_due_nxt;
  logic [AW-1:0] ha_r, ha_nxt;
  logic          hwe_r, hwe_nxt;
  logic [DW-1:0] hwd_r, hwd_nxt;
  logic [DW-1:0] cd_r, cd_nxt;
  logic          rv_r, rv_nxt;
  logic [DW-1:0] rd_r, rd_nxt;
  logic          fat_r, fat_nxt;
  logic          mir_wr_r, mir_wr_nxt;
  logic          spare_r, spare_nxt;
  logic [DIW-1:0] bad_dimm_r, bad_dimm_nxt;
  logic [DCW-1:0] dcnt_r [NDIMM];
  logic [DCW-1:0] dcnt_nxt [NDIMM];
  logic          ce_hit;
  logic          sc_ce_hit;
  logic [1:0]    tdis;
  logic          mirror_on;
  logic          spare_mode;
  logic [DIW-1:0] dimm_of;

  // Mode selection: mirroring wins, spare mode is excluded then
  assign mirror_on  = mirror_en;
  assign spare_mode = spare_en && !mirror_en;
  assign active_mode = mirror_on ? mrem_pkg::MREM_MODE_MIRROR :
                       (spare_mode ? mrem_pkg::MREM_MODE_SPARE : mrem_pkg::MREM_MODE_PLAIN);

  // DIMM index from the top address bits of the current access
  assign dimm_of = mem_addr[AW-1 -: DIW];

  // Correctable events feeding the throttles
  assign ce_hit    = mem_ack && mem_ce_err && (st_r == mrem_pkg::MREM_HOST);
  assign sc_ce_hit = mem_ack && mem_ce_err && (st_r == mrem_pkg::MREM_SCRUB);

  // One throttle per tracked error type
  mrem_throttle #(.CW(8)) u_thr_ce (
    .clk        (clk),
    .nrst       (nrst),
    .ce         (ce),
    .hour_tick  (hour_tick),
    .err_evt    (ce_hit),
    .report_evt (log_event),
    .off_evt    (log_off_event),
    .disabled   (tdis[`MREM_TYPE_CE])
  );
  logic sc_rep;
  logic sc_off;
  mrem_throttle #(.CW(8)) u_thr_sc (
    .clk        (clk),
    .nrst       (nrst),
    .ce         (ce),
    .hour_tick  (hour_tick),
    .err_evt    (sc_ce_hit),
    .report_evt (sc_rep),
    .off_evt    (sc_off),
    .disabled   (tdis[`MREM_TYPE_SCRUB])
  );
  assign system_management_interrupt = log_event | log_off_event | sc_rep | sc_off;

  // Access sequencer, scrub timer and sparing counters
  always_comb begin
    st_nxt       = st_r;
    tmr_nxt      = tmr_r;
    sc_addr_nxt  = sc_addr_r;
    sc_due_nxt   = sc_due_r;
    ha_nxt       = ha_r;
    hwe_nxt      = hwe_r;
    hwd_nxt      = hwd_r;
    cd_nxt       = cd_r;
    rv_nxt       = 1'b0;
    rd_nxt       = rd_r;
    fat_nxt      = 1'b0;
    mir_wr_nxt   = mir_wr_r;
    spare_nxt    = spare_r;
    bad_dimm_nxt = bad_dimm_r;
    for (int i = 0; i < NDIMM; i++) begin
      dcnt_nxt[i] = dcnt_r[i];
    end
    if (tmr_r == 32'(INTERVAL - 1)) begin
      tmr_nxt    = '0;
      sc_due_nxt = 1'b1;
    end else begin
      tmr_nxt = tmr_r + 32'd1;
    end
    case (st_r)
      mrem_pkg::MREM_IDLE: begin
        if (sc_due_r) begin
          sc_due_nxt = 1'b0;
          st_nxt     = mrem_pkg::MREM_SCRUB;
        end else if (host_req && !host_addr_err) begin
          ha_nxt     = host_addr;
          hwe_nxt    = host_we;
          hwd_nxt    = host_wdata;
          mir_wr_nxt = 1'b0;
          st_nxt     = mrem_pkg::MREM_HOST;
        end
      end
      mrem_pkg::MREM_HOST: begin
        if (mem_ack) begin
          if (hwe_r) begin
            if (mirror_on && !mir_wr_r) begin
              mir_wr_nxt = 1'b1;
            end else begin
              st_nxt = mrem_pkg::MREM_IDLE;
            end
          end else if (mem_ue_err && mirror_on) begin
            st_nxt = mrem_pkg::MREM_MIRROR;
          end else begin
            rv_nxt = 1'b1;
            rd_nxt = mem_ce_err ? mem_corr_data : mem_rdata;
            fat_nxt = mem_ue_err;
            st_nxt  = mrem_pkg::MREM_IDLE;
          end
          if (mem_ce_err && spare_mode && !spare_r) begin
            dcnt_nxt[dimm_of] = dcnt_r[dimm_of] + DCW'(1);
            if (dcnt_r[dimm_of] >= spare_threshold) begin
              spare_nxt    = 1'b1;
              bad_dimm_nxt = dimm_of;
            end
          end
        end
      end
      mrem_pkg::MREM_MIRROR: begin
        if (mem_ack) begin
          rv_nxt  = 1'b1;
          rd_nxt  = mem_ce_err ? mem_corr_data : mem_rdata;
          fat_nxt = mem_ue_err;
          st_nxt  = mrem_pkg::MREM_IDLE;
        end
      end
      mrem_pkg::MREM_SCRUB: begin
        if (mem_ack) begin
          if (mem_ce_err) begin
            cd_nxt = mem_corr_data;
            st_nxt = mrem_pkg::MREM_WBACK;
          end else begin
            sc_addr_nxt = sc_addr_r + AW'(1);
            st_nxt      = mrem_pkg::MREM_IDLE;
          end
        end
      end
      mrem_pkg::MREM_WBACK: begin
        if (mem_ack) begin
          sc_addr_nxt = sc_addr_r + AW'(1);
          st_nxt      = mrem_pkg::MREM_IDLE;
        end
      end
      default: st_nxt = mrem_pkg::MREM_IDLE;
    endcase
  end

  // State registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r       <= mrem_pkg::MREM_IDLE;
      tmr_r      <= '0;
      sc_addr_r  <= '0;
      sc_due_r   <= 1'b0;
      ha_r       <= '0;
      hwe_r      <= 1'b0;
      hwd_r      <= '0;
      cd_r       <= '0;
      rv_r       <= 1'b0;
      rd_r       <= '0;
      fat_r      <= 1'b0;
      mir_wr_r   <= 1'b0;
      spare_r    <= 1'b0;
      bad_dimm_r <= '0;
      for (int i = 0; i < NDIMM; i++) begin
        dcnt_r[i] <= '0;
      end
    end else if (ce) begin
      st_r       <= st_nxt;
      tmr_r      <= tmr_nxt;
      sc_addr_r  <= sc_addr_nxt;
      sc_due_r   <= sc_due_nxt;
      ha_r       <= ha_nxt;
      hwe_r      <= hwe_nxt;
      hwd_r      <= hwd_nxt;
      cd_r       <= cd_nxt;
      rv_r       <= rv_nxt;
      rd_r       <= rd_nxt;
      fat_r      <= fat_nxt;
      mir_wr_r   <= mir_wr_nxt;
      spare_r    <= spare_nxt;
      bad_dimm_r <= bad_dimm_nxt;
      for (int i = 0; i < NDIMM; i++) begin
        dcnt_r[i] <= dcnt_nxt[i];
      end
    end
  end

  // Host side: taken only in idle with no scrub pending
  assign host_ready    = ce && (st_r == mrem_pkg::MREM_IDLE) && !sc_due_r;
  assign host_addr_err = mirror_on && host_addr[AW-1];
  assign host_rvalid   = rv_r;
  assign host_rdata    = rd_r;
  assign fatal_err     = fat_r;
  assign spare_active  = spare_r && spare_mode;

  // Memory side; the mirror copy lives in the upper half
  always_comb begin
    mem_req   = 1'b0;
    mem_we    = 1'b0;
    mem_addr  = ha_r;
    mem_wdata = hwd_r;
    case (st_r)
      mrem_pkg::MREM_HOST: begin
        mem_req  = 1'b1;
        mem_we   = hwe_r;
        mem_addr = mirror_on ? {mir_wr_r, ha_r[AW-2:0]} : ha_r;
      end
      mrem_pkg::MREM_MIRROR: begin
        mem_req  = 1'b1;
        mem_addr = {1'b1, ha_r[AW-2:0]};
      end
      mrem_pkg::MREM_SCRUB: begin
        mem_req  = 1'b1;
        mem_addr = sc_addr_r;
      end
      mrem_pkg::MREM_WBACK: begin
        mem_req   = 1'b1;
        mem_we    = 1'b1;
        mem_addr  = sc_addr_r;
        mem_wdata = cd_r;
      end
      default: mem_req = 1'b0;
    endcase
  end
  assign mem_use_spare = spare_active && (dimm_of == bad_dimm_r);

  AST_WBACK_SAME: assert property (@(posedge clk) disable iff (!nrst)
    (ce && st_r == mrem_pkg::MREM_SCRUB && mem_ack && mem_ce_err) |=>
      (st_r == mrem_pkg::MREM_WBACK && mem_we && mem_addr == $past(sc_addr_r)))
    else $error("scrub write-back missing");
  AST_MODES_EXCL: assert property (@(posedge clk) disable iff (!nrst)
    !(mirror_on && spare_active)) else $error("sparing and mirroring together");
  AST_HALF: assert property (@(posedge clk) disable iff (!nrst)
    (host_req && host_ready && host_addr_err) |=> st_r == mrem_pkg::MREM_IDLE)
    else $error("upper half accepted while mirroring");
  AST_NO_READY_WB: assert property (@(posedge clk) disable iff (!nrst)
    (st_r == mrem_pkg::MREM_WBACK) |-> !host_ready) else $error("host taken during write-back");
  AST_WRAP: assert property (@(posedge clk) disable iff (!nrst)
    (ce && mem_ack && sc_addr_r == '1 && (st_r == mrem_pkg::MREM_WBACK ||
      (st_r == mrem_pkg::MREM_SCRUB && !mem_ce_err))) |=> sc_addr_r == '0)
    else $error("scrub address did not wrap");
endmodule

// ---- sim/mrem_dimm_model.sv ----
`timescale 1ns/1ns
// DIMM array with selectable latency and injected errors
module mrem_dimm_model #(
  parameter int AW = 8,
  parameter int DW = 16
) (
  input  wire logic          clk,
  input  wire logic          mem_req,
  input  wire logic          mem_we,
  input  wire logic [AW-1:0] mem_addr,
  input  wire logic [DW-1:0] mem_wdata,
  input  wire logic          slow,
  input  wire logic          inj_ce,
  input  wire logic          inj_ue,
  input  wire logic          inj_any,
  input  wire logic [AW-1:0] inj_addr,
  output logic               mem_ack,
  output logic [DW-1:0]      mem_rdata,
  output logic               mem_ce_err,
  output logic               mem_ue_err,
  output logic [DW-1:0]      mem_corr_data
);
  logic [DW-1:0] arr [2**AW];
  logic [DW-1:0] dat  = '0;
  logic [2:0]    cnt  = 3'h0;
  logic          ce_r = 1'b0;
  logic          ue_r = 1'b0;
  logic          hit;
  // Contents start from a pattern the bench recomputes
  initial begin
    mem_ack = 1'b0;
    for (int i = 0; i < 2**AW; i++) arr[i] = ~DW'(i);
  end
  // Outside an answer the lines show garbage, never the last word
  assign hit           = inj_any || (mem_addr == inj_addr);
  assign mem_rdata     = (!mem_ack || ue_r) ? ~dat : dat ^ {{(DW-1){1'b0}}, ce_r};
  assign mem_corr_data = (mem_ack && !ue_r) ? dat : ~dat;
  assign mem_ce_err    = mem_ack ? ce_r : cnt[0];
  assign mem_ue_err    = mem_ack ? ue_r : cnt[1];
  // One answer per request, after zero or three wait cycles
  always @(posedge clk) begin
    if (mem_req && !mem_ack && cnt >= (slow ? 3'h3 : 3'h0)) begin
      mem_ack <= 1'b1;
      cnt     <= 3'h0;
      dat     <= arr[mem_addr];
      ce_r    <= !mem_we && inj_ce && hit;
      ue_r    <= !mem_we && inj_ue && hit;
      if (mem_we) arr[mem_addr] <= mem_wdata;
    end else begin
      mem_ack <= 1'b0;
      if (mem_req && !mem_ack) cnt <= cnt + 3'h1;
    end
  end
endmodule

// ---- sim/tb.sv ----
`timescale 1ns/1ns
`define CHK(n, e, s) begin num_checks++; if ((e) !== (s)) begin err_total++; $display("[ERR] %s exp %0h got %0h", n, e, s); end end
module tb;
  localparam int AW = 8;
  localparam int DW = 16;
  localparam int IV = 16;
  logic clk = 0, nrst = 0, ce = 1, hour_tick = 0, spare_en = 0, mirror_en = 0;
  logic host_req = 0, host_we = 0, slow = 0, inj_ce = 0, inj_ue = 0, inj_any = 0;
  logic [7:0]    spare_threshold = 8'h03;
  logic [AW-1:0] host_addr = '0, inj_addr = '0, a, mem_addr, sa, wa;
  logic [DW-1:0] host_wdata = '0, host_rdata, mem_wdata, mem_rdata, mem_corr_data, rd, wbd;
  logic host_ready, host_rvalid, host_addr_err, mem_req, mem_we, mem_use_spare, mem_ack;
  logic mem_ce_err, mem_ue_err, log_event, log_off_event, system_management_interrupt;
  logic fatal_err, spare_active, fat_s, usp, we, req_q, ack_q, mon = 0;
  logic [1:0]    active_mode;
  logic [DW-1:0] shadow [2**AW];
  int err_total = 0, num_checks = 0, n_log = 0, n_off = 0, n_smi = 0, nsr = 0, nwb = 0;

  mrem_core #(.AW(AW), .DW(DW), .NDIMM(4), .DCW(8), .INTERVAL(IV)) i_mrem_core (
    .clk, .nrst, .ce, .hour_tick, .spare_en, .mirror_en, .spare_threshold,
    .host_req, .host_we, .host_addr, .host_wdata, .host_ready, .host_rvalid,
    .host_rdata, .host_addr_err, .mem_req, .mem_we, .mem_addr, .mem_wdata,
    .mem_use_spare, .mem_ack, .mem_rdata, .mem_ce_err, .mem_ue_err, .mem_corr_data,
    .log_event, .log_off_event, .system_management_interrupt, .fatal_err,
    .active_mode, .spare_active);
  mrem_dimm_model #(.AW(AW), .DW(DW)) i_mrem_dimm_model (
    .clk, .mem_req, .mem_we, .mem_addr, .mem_wdata, .slow, .inj_ce, .inj_ue, .inj_any,
    .inj_addr, .mem_ack, .mem_rdata, .mem_ce_err, .mem_ue_err, .mem_corr_data);

  always #10 clk = ~clk;

  // Event counting and scrub watching on settled values
  always @(negedge clk) begin
    req_q <= mem_req;
    ack_q <= mem_ack;
    if (nrst) begin
      n_log += log_event;
      n_off += log_off_event;
      n_smi += system_management_interrupt;
    end
    if (mon && mem_req && (!req_q || ack_q)) begin
      if (mem_we) begin
        nwb++;
        wa = mem_addr;
        wbd = mem_wdata;
      end else begin
        if (nsr > 0) `CHK("scrub addr", sa + 8'h01, mem_addr)
        sa = mem_addr;
        nsr++;
      end
    end
  end

  task automatic conclude();
    if (err_total == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Reboot with chosen modes; outputs must be quiet in reset
  task automatic reboot(input logic sp, input logic mi);
    @(posedge clk);
    #1 nrst = 0;
    spare_en = sp;
    mirror_en = mi;
    repeat (3) @(posedge clk);
    `CHK("reset outs", 7'h00, {host_rvalid, mem_req, log_event, log_off_event, fatal_err, spare_active, system_management_interrupt})
    #1 nrst = 1;
    n_log = 0;
    n_off = 0;
    n_smi = 0;
  endtask

  // One host access, held until taken, then waited out
  task automatic op(input logic w, input logic [AW-1:0] ad, input logic [DW-1:0] d);
    int k;
    @(posedge clk);
    #1 host_req = 1;
    host_we = w;
    host_addr = ad;
    host_wdata = d;
    k = 0;
    do begin @(negedge clk); k++; end while (host_ready !== 1'b1 && k < 300);
    if (!mirror_en) `CHK("addr err", 1'b0, host_addr_err)
    @(posedge clk);
    #1 host_req = 0;
    host_addr = ~ad;
    host_wdata = ~d;
    if (w) shadow[ad] = d;
    fat_s = 0;
    usp = 0;
    k = 0;
    do begin
      @(negedge clk);
      k++;
      if (mem_req === 1'b1 && mem_addr === ad) usp = mem_use_spare;
      if (host_rvalid === 1'b1) begin rd = host_rdata; fat_s = fatal_err; end
    end while (k < 300 && !(w ? host_ready === 1'b1 : host_rvalid === 1'b1));
    `CHK("op done", 1, int'(k < 300))
  endtask

  task automatic settle();
    repeat (3) @(posedge clk);
  endtask

  initial begin
    #400000;
    err_total++;
    conclude();
  end

  initial begin
    void'($urandom(86));
    for (int i = 0; i < 2**AW; i++) shadow[i] = ~DW'(i);
    reboot(0, 0);
    // Random traffic that collides with scrub write-backs, mixed latency
    inj_any = 1;
    inj_ce = 1;
    for (int i = 0; i < 60; i++) begin
      a = AW'($urandom);
      we = $urandom % 2;
      slow = $urandom % 2;
      op(we, a, DW'($urandom));
      if (!we) `CHK("rdata", shadow[a], rd)
    end
    slow = 0;
    inj_any = 0;
    inj_ce = 0;
    // Hourly window, shut-off, silent correction
    reboot(0, 0);
    inj_addr = 8'hC0;
    inj_ce = 1;
    repeat (5) op(0, 8'hC0, 0);
    settle();
    `CHK("corrected", shadow[8'hC0], rd)
    `CHK("logs", 5, n_log)
    #1 hour_tick = 1;
    @(posedge clk);
    #1 hour_tick = 0;
    repeat (9) op(0, 8'hC0, 0);
    settle();
    `CHK("logs", 14, n_log)
    `CHK("off", 0, n_off)
    op(0, 8'hC0, 0);
    settle();
    `CHK("off", 1, n_off)
    `CHK("logs", 14, n_log)
    repeat (3) op(0, 8'hC0, 0);
    settle();
    `CHK("corrected", shadow[8'hC0], rd)
    `CHK("logs", 14, n_log)
    `CHK("smi", 15, n_smi)
    reboot(0, 0);
    op(0, 8'hC0, 0);
    settle();
    `CHK("logs", 1, n_log)
    inj_ce = 0;
    inj_ue = 1;
    op(0, 8'hC0, 0);
    `CHK("fatal", 1'b1, fat_s)
    // Mirroring wins over sparing; copy answers a bad read
    reboot(1, 1);
    `CHK("mode", 3'h4, {active_mode, spare_active})
    inj_ue = 0;
    op(1, 8'h35, 16'hBEEF);
    `CHK("copy", 16'hBEEF, i_mrem_dimm_model.arr[8'hB5])
    inj_addr = 8'h35;
    inj_ue = 1;
    op(0, 8'h35, 0);
    `CHK("mirror data", 16'hBEEF, rd)
    `CHK("fatal", 1'b0, fat_s)
    inj_ue = 0;
    @(posedge clk);
    #1 host_req = 1;
    host_addr = 8'h85;
    @(negedge clk);
    `CHK("addr err", 1'b1, host_addr_err)
    @(posedge clk);
    #1 host_req = 0;
    // Sparing after the threshold
    reboot(1, 0);
    `CHK("mode", 3'h2, {active_mode, spare_active})
    inj_addr = 8'h50;
    inj_ce = 1;
    repeat (2) op(0, 8'h50, 0);
    `CHK("spare", 1'b0, spare_active)
    repeat (2) op(0, 8'h50, 0);
    `CHK("spare", 1'b1, spare_active)
    op(0, 8'h50, 0);
    `CHK("use spare", 1'b1, usp)
    op(0, 8'h10, 0);
    `CHK("use spare", 1'b0, usp)
    inj_ce = 0;
    // Scrub rate, wrap-around and write-back
    reboot(0, 0);
    ce = 0;
    mon = 1;
    repeat (IV * 3) @(posedge clk);
    `CHK("frozen scrub", 0, nsr)
    #1 ce = 1;
    // First read comes one interval plus one cycle after the timer starts
    repeat (IV * 64 + 2) @(posedge clk);
    `CHK("scrub rate", 64, nsr)
    repeat (IV * 200) @(posedge clk);
    #1 inj_any = 1;
    inj_ce = 1;
    for (int k = 0; k < 60 && nwb == 0; k++) @(posedge clk);
    #1 inj_any = 0;
    inj_ce = 0;
    `CHK("wback", 1, nwb)
    `CHK("wback addr", sa, wa)
    `CHK("wback data", shadow[wa], wbd)
    conclude();
  end
endmodule
